// ===== logic/flash_spm_map.svh
`ifndef FLASH_SPM_MAP_SVH
`define FLASH_SPM_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CTRL_OFS        4'h0
`define STAT_OFS        4'h1

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SPE_BIT         0
`define CMD_LSB         1
`define CMD_MSB         5
`define RBUSY_BIT       6
`define CTRL_RESET      6'h00

// Command field, bits 5..1
`define CMD_LOAD        5'h00
`define CMD_ERASE       5'h01
`define CMD_WRITE       5'h02
`define CMD_FUSE_LOCK   5'h04
`define CMD_REEN        5'h08
`define CMD_SIG         5'h10

// ----------------------------------------
// Acceptance windows
// ----------------------------------------
`define WIN_SPM         3'h4
`define WIN_LPM_LAST    3'h2
`define WIN_SPM_LAST    3'h1

// ----------------------------------------
// Pointer addresses for special reads
// ----------------------------------------
`define Z_FUSE_LOW      16'h0000
`define Z_LOCK          16'h0001
`define Z_FUSE_EXT      16'h0002
`define Z_FUSE_HIGH     16'h0003
`define Z_SIG1          16'h0000
`define Z_OSC_CAL       16'h0001
`define Z_SIG2          16'h0002
`define Z_SIG3          16'h0004
`define RESERVED_BYTE   8'hFF

// ----------------------------------------
// Flash geometry
// ----------------------------------------
`define FLASH_TOP_LARGE 14'h3FFF
`define BOOT_MIN_WORDS  14'h0100
`define NO_READ_WHILE_WRITE_REGION_WORDS      14'h0800

// ----------------------------------------
// Write timing
// ----------------------------------------
`define PROG_MIN_US     3700
`define PROG_MAX_US     4500
`define RC_OSC_KHZ      8000
`define PROG_TICKS      ((`PROG_MIN_US * `RC_OSC_KHZ + 999) / 1000)

`endif

// ===== logic/flash_spm_pkg.sv
package flash_spm_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_PROG  = 3'b100
  } spm_state_t;

  typedef enum logic [1:0] {
    OP_ERASE = 2'h0,
    OP_WRITE = 2'h1,
    OP_LOCK  = 2'h2
  } prog_op_t;

endpackage

// ===== logic/flash_write_timer.sv
`timescale 1ns/1ns
`include "flash_spm_map.svh"

module flash_write_timer import flash_spm_pkg::*; #(
  parameter int PROG_TICKS = `PROG_TICKS
) (
  input  wire logic       ref_clk,
  input  wire logic       por_n,
  input  wire logic       rc_osc,
  input  wire logic       start,
  input  prog_op_t        op,
  input  wire logic [7:0] page,
  output logic            busy,
  output logic            done,
  output logic            erase,
  output logic            write,
  output logic            lock_write,
  output logic [7:0]      page_out
);

  localparam logic [15:0] TICKS = 16'(PROG_TICKS);

  logic       rc_s1_q, rc_s2_q, rc_s3_q;
  logic       busy_q, busy_d, done_q, done_d;
  logic [2:0] op_q, op_d;
  logic [7:0] page_q, page_d;
  logic [15:0] cnt_q, cnt_d;
  logic       rc_edge;

  // ----------------------------------------
  // Oscillator edge count, survives system reset
  // ----------------------------------------
  assign rc_edge = rc_s2_q & ~rc_s3_q;

  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    op_d   = op_q;
    page_d = page_q;
    cnt_d  = cnt_q;
    if (!busy_q && start) begin
      busy_d = 1'b1;
      cnt_d  = 16'h0000;
      page_d = page;
      op_d   = {op == OP_LOCK, op == OP_WRITE, op == OP_ERASE};
    end else if (busy_q && rc_edge) begin
      if (cnt_q == TICKS - 16'h0001) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        op_d   = 3'h0;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      op_q    <= 3'h0;
      page_q  <= 8'h00;
      cnt_q   <= 16'h0000;
    end else begin
      rc_s1_q <= rc_osc;
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
      busy_q  <= busy_d;
      done_q  <= done_d;
      op_q    <= op_d;
      page_q  <= page_d;
      cnt_q   <= cnt_d;
    end
  end

  assign busy       = busy_q;
  assign done       = done_q;
  assign erase      = op_q[0];
  assign write      = op_q[1];
  assign lock_write = op_q[2];
  assign page_out   = page_q;

endmodule

// ===== logic/flash_selfprog.sv
`timescale 1ns/1ns
`include "flash_spm_map.svh"

module flash_selfprog import flash_spm_pkg::*; #(
  parameter logic [13:0] FLASH_TOP  = `FLASH_TOP_LARGE,
  parameter int          PROG_TICKS = `PROG_TICKS,
  // Arbitrary identification values
  parameter logic [7:0]  SIG_BYTE1  = 8'hA5,
  parameter logic [7:0]  SIG_BYTE2  = 8'h5A,
  parameter logic [7:0]  SIG_BYTE3  = 8'h3C
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic [15:0] z_ptr,
  input  wire logic [15:0] r1r0,
  input  wire logic        lpm_req,
  input  wire logic        spm_req,
  input  wire logic [7:0]  flash_rdata,
  output logic [7:0]       lpm_data,
  input  wire logic [7:0]  fuse_low_prog,
  input  wire logic [7:0]  fuse_high_prog,
  input  wire logic [2:0]  fuse_ext_prog,
  input  wire logic [5:0]  lock_prog,
  input  wire logic [7:0]  osc_cal,
  input  wire logic [1:0]  boot_size_fuses,
  input  wire logic        eeprom_write_pending,
  input  wire logic        rc_osc,
  input  wire logic [13:0] fetch_addr,
  output logic             fetch_blocked,
  output logic [13:0]      boot_start,
  output logic             region_busy_flag,
  output logic             buf_load,
  output logic             buf_clear,
  output logic [5:0]       buf_word,
  output logic [15:0]      buf_data,
  output logic             flash_busy,
  output logic             flash_erase,
  output logic             flash_write,
  output logic             lock_write,
  output logic [7:0]       flash_page
);

  localparam logic [13:0] RWW_TOP = FLASH_TOP - `NO_READ_WHILE_WRITE_REGION_WORDS;

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic in_rww(input logic [13:0] a);
    in_rww = (a <= RWW_TOP);
  endfunction

  function automatic logic [7:0] fuse_byte(input logic [15:0] z,
      input logic [7:0] lo, input logic [7:0] hi,
      input logic [2:0] ext, input logic [5:0] lk);
    case (z)
      `Z_FUSE_LOW:  fuse_byte = ~lo;
      `Z_LOCK:      fuse_byte = {2'b11, ~lk};
      `Z_FUSE_EXT:  fuse_byte = {5'h1F, ~ext};
      `Z_FUSE_HIGH: fuse_byte = ~hi;
      default:      fuse_byte = `RESERVED_BYTE;
    endcase
  endfunction

  function automatic logic [7:0] sig_byte(input logic [15:0] z,
      input logic [7:0] cal);
    case (z)
      `Z_SIG1:    sig_byte = SIG_BYTE1;
      `Z_OSC_CAL: sig_byte = cal;
      `Z_SIG2:    sig_byte = SIG_BYTE2;
      `Z_SIG3:    sig_byte = SIG_BYTE3;
      default:    sig_byte = `RESERVED_BYTE;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  spm_state_t  st_q, st_d;
  prog_op_t    op;
  logic [5:0]  ctrl_q, ctrl_d;
  logic [2:0]  cnt_q, cnt_d;
  logic        rbusy_q, rbusy_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [7:0]  lpm_q, lpm_d;
  logic        blk_q, blk_d;
  logic [13:0] boot_q, boot_d;
  logic        load_q, load_d, clr_q, clr_d;
  logic [5:0]  word_q, word_d;
  logic [15:0] data_q, data_d;
  logic        start;
  logic        tmr_busy, tmr_done;
  logic [4:0]  cmd;
  logic        fuse_sel, sig_sel, lpm_ok, spm_ok;
  logic [13:0] page_addr;
  logic [13:0] boot_words;

  assign cmd       = ctrl_q[`CMD_MSB:`CMD_LSB];
  assign fuse_sel  = (cmd == `CMD_FUSE_LOCK);
  assign sig_sel   = (cmd == `CMD_SIG);
  assign lpm_ok    = (st_q == ST_ARMED) && (cnt_q >= `WIN_LPM_LAST);
  assign spm_ok    = (st_q == ST_ARMED) && (cnt_q != 3'h0);
  assign page_addr = {z_ptr[14:7], 6'h00};
  assign boot_words = 14'(`BOOT_MIN_WORDS << ~boot_size_fuses);

  // ----------------------------------------
  // Command sequencing
  // ----------------------------------------
  always_comb begin
    st_d    = st_q;
    ctrl_d  = ctrl_q;
    rbusy_d = rbusy_q;
    load_d  = 1'b0;
    clr_d   = 1'b0;
    word_d  = word_q;
    data_d  = data_q;
    start   = 1'b0;
    op      = OP_ERASE;
    cnt_d   = (cnt_q != 3'h0) ? cnt_q - 3'h1 : 3'h0;
    case (st_q)
      ST_IDLE: begin
        // Ignored while eeprom or flash write is busy
        if (reg_wr && reg_addr == `CTRL_OFS && reg_wdata[`SPE_BIT] &&
            !eeprom_write_pending && !tmr_busy) begin
          ctrl_d = reg_wdata[5:0];
          cnt_d  = `WIN_SPM;
          st_d   = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (lpm_req && lpm_ok && (fuse_sel || sig_sel)) begin
          ctrl_d = `CTRL_RESET;
          st_d   = ST_IDLE;
        end else if (spm_req && spm_ok && !sig_sel) begin
          ctrl_d = `CTRL_RESET;
          st_d   = ST_IDLE;
          case (cmd)
            `CMD_LOAD: begin
              load_d = 1'b1;
              word_d = z_ptr[6:1];
              data_d = r1r0;
            end
            `CMD_ERASE, `CMD_WRITE, `CMD_FUSE_LOCK: begin
              start  = 1'b1;
              op     = (cmd == `CMD_ERASE) ? OP_ERASE :
                       (cmd == `CMD_WRITE) ? OP_WRITE : OP_LOCK;
              data_d = r1r0;
              ctrl_d = ctrl_q;
              st_d   = ST_PROG;
              if (cmd != `CMD_FUSE_LOCK && in_rww(page_addr)) begin
                rbusy_d = 1'b1;
              end
            end
            `CMD_REEN: begin
              if (!tmr_busy) begin
                rbusy_d = 1'b0;
                clr_d   = 1'b1;
              end
            end
            default: ;
          endcase
        end else if ((sig_sel && cnt_q == `WIN_LPM_LAST) ||
                     cnt_q == `WIN_SPM_LAST) begin
          ctrl_d = `CTRL_RESET;
          st_d   = ST_IDLE;
        end
      end
      ST_PROG: begin
        if (tmr_done) begin
          ctrl_d = `CTRL_RESET;
          st_d   = ST_IDLE;
        end
      end
      default: begin
        ctrl_d = `CTRL_RESET;
        st_d   = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Load data, register reads, region map
  // ----------------------------------------
  always_comb begin
    lpm_d = lpm_q;
    if (lpm_req) begin
      if (lpm_ok && fuse_sel) begin
        lpm_d = fuse_byte(z_ptr, fuse_low_prog, fuse_high_prog,
                          fuse_ext_prog, lock_prog);
      end else if (lpm_ok && sig_sel) begin
        lpm_d = sig_byte(z_ptr, osc_cal);
      end else begin
        lpm_d = flash_rdata;
      end
    end
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `CTRL_OFS: rdata_d = {1'b0, rbusy_q, ctrl_q[5:1],
                              ctrl_q[`SPE_BIT] | tmr_busy};
        `STAT_OFS: rdata_d = {6'h00, eeprom_write_pending, tmr_busy};
        default:   rdata_d = 8'h00;
      endcase
    end
    blk_d  = in_rww(fetch_addr) && (rbusy_q || tmr_busy);
    boot_d = FLASH_TOP - boot_words + 14'h0001;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= ST_IDLE;
      ctrl_q  <= `CTRL_RESET;
      cnt_q   <= 3'h0;
      rbusy_q <= 1'b0;
      rdata_q <= 8'h00;
      lpm_q   <= 8'h00;
      blk_q   <= 1'b0;
      boot_q  <= 14'h0000;
      load_q  <= 1'b0;
      clr_q   <= 1'b0;
      word_q  <= 6'h00;
      data_q  <= 16'h0000;
    end else begin
      st_q    <= st_d;
      ctrl_q  <= ctrl_d;
      cnt_q   <= cnt_d;
      rbusy_q <= rbusy_d;
      rdata_q <= rdata_d;
      lpm_q   <= lpm_d;
      blk_q   <= blk_d;
      boot_q  <= boot_d;
      load_q  <= load_d;
      clr_q   <= clr_d;
      word_q  <= word_d;
      data_q  <= data_d;
    end
  end

  // ----------------------------------------
  // Write timer
  // ----------------------------------------
  flash_write_timer #(
    .PROG_TICKS (PROG_TICKS)
  ) u_timer (
    .ref_clk    (ref_clk),
    .por_n      (por_n),
    .rc_osc     (rc_osc),
    .start      (start),
    .op         (op),
    .page       (z_ptr[14:7]),
    .busy       (tmr_busy),
    .done       (tmr_done),
    .erase      (flash_erase),
    .write      (flash_write),
    .lock_write (lock_write),
    .page_out   (flash_page)
  );

  assign reg_rdata        = rdata_q;
  assign lpm_data         = lpm_q;
  assign fetch_blocked    = blk_q;
  assign boot_start       = boot_q;
  assign region_busy_flag = rbusy_q;
  assign buf_load         = load_q;
  assign buf_clear        = clr_q;
  assign buf_word         = word_q;
  assign buf_data         = data_q;
  assign flash_busy       = tmr_busy;

endmodule

// ===== sim/flash_selfprog_assertions.sv
`timescale 1ns/1ns
module flash_selfprog_assertions import flash_spm_pkg::*; #(
  parameter logic [13:0] FLASH_TOP  = 14'h3FFF,
  parameter int          PROG_TICKS = 8
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        por_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic [15:0] z_ptr,
  input wire logic        lpm_req,
  input wire logic        spm_req,
  input wire logic [7:0]  flash_rdata,
  input wire logic [7:0]  lpm_data,
  input wire logic [7:0]  fuse_high_prog,
  input wire logic [2:0]  fuse_ext_prog,
  input wire logic [7:0]  osc_cal,
  input wire logic [1:0]  boot_size_fuses,
  input wire logic        eeprom_write_pending,
  input wire logic [13:0] fetch_addr,
  input wire logic        fetch_blocked,
  input wire logic [13:0] boot_start,
  input wire logic        region_busy_flag,
  input wire logic        flash_busy,
  input wire logic        flash_erase
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  localparam logic [13:0] RWW_END = FLASH_TOP - 14'h0800;
  localparam int T_MIN = (PROG_TICKS - 1) * 3;
  localparam int T_MAX = PROG_TICKS * 4 + 8;
  int busy_n_q;
  int busy_n_d;
  // Busy length survives system reset
  always_comb busy_n_d = flash_busy ? busy_n_q + 1 : 0;
  always_ff @(posedge ref_clk or negedge por_n)
    if (!por_n) busy_n_q <= 0;
    else busy_n_q <= busy_n_d;
  sequence arm(logic [7:0] val);
    reg_wr && reg_addr == 4'h0 && reg_wdata == val && !flash_busy
      && !eeprom_write_pending;
  endsequence
  chk_fuse_high:
  assert property (arm(8'h09) ##3 lpm_req && z_ptr == 16'h0003
    |=> lpm_data == ~$past(fuse_high_prog)) else $error("high fuse bad");
  chk_fuse_ext:
  assert property (arm(8'h09) ##1 lpm_req && z_ptr == 16'h0002
    |=> lpm_data == {5'h1F, ~$past(fuse_ext_prog)}) else $error("ext bad");
  chk_sig_cal:
  assert property (arm(8'h21) ##[1:3] lpm_req && z_ptr == 16'h0001
    |=> lpm_data == $past(osc_cal)) else $error("cal byte bad");
  chk_sig_expire:
  assert property (arm(8'h21) ##1 !lpm_req [*3] ##1 lpm_req
    |=> lpm_data == $past(flash_rdata)) else $error("late load bad");
  chk_erase_start:
  assert property (arm(8'h03) ##1 spm_req |=> flash_busy && flash_erase)
    else $error("erase not started");
  chk_prog_time:
  assert property ($fell(flash_busy) |-> busy_n_q >= T_MIN
    && busy_n_q <= T_MAX) else $error("write time bad");
  chk_region_hold:
  assert property (region_busy_flag && !spm_req && !$past(spm_req)
    |=> region_busy_flag) else $error("region flag dropped");
  chk_top_open:
  assert property ($past(fetch_addr) > RWW_END |-> !fetch_blocked)
    else $error("top region blocked");
  chk_low_shut:
  assert property ($past(region_busy_flag) && $past(fetch_addr) <= RWW_END
    |-> fetch_blocked) else $error("low region open");
  chk_boot_start:
  assert property ($past(rst_n) |-> boot_start == FLASH_TOP + 14'h1
    - (14'h0100 << ~$past(boot_size_fuses))) else $error("boot start bad");
  cover property (arm(8'h09) ##1 lpm_req);
  cover property ($fell(flash_busy));
  cover property ($fell(region_busy_flag));
endmodule

bind flash_selfprog flash_selfprog_assertions #(
  .FLASH_TOP (FLASH_TOP),
  .PROG_TICKS(PROG_TICKS)
) u_chk (.*);

// ===== sim/boot_core_model.sv
`timescale 1ns/1ns
module boot_core_model (
  input  wire logic   ref_clk,
  output logic [15:0] z_ptr,
  output logic [15:0] r1r0,
  output logic        lpm_req,
  output logic        spm_req,
  output logic [7:0]  flash_rdata,
  output logic        rc_osc,
  output logic        eeprom_write_pending
);
  // Array byte valid in load cycle only
  assign flash_rdata = {8{~lpm_req}} ^ z_ptr[7:0] ^ 8'h5A;
  initial begin
    z_ptr = 16'h0000;
    r1r0 = 16'h0000;
    lpm_req = 1'b0;
    spm_req = 1'b0;
    eeprom_write_pending = 1'b0;
    rc_osc = 1'b0;
    #7;
    forever #62 rc_osc = ~rc_osc;
  end
  task automatic load(input logic [15:0] z, input int gap);
    repeat (gap) @(posedge ref_clk);
    z_ptr   <= z;
    lpm_req <= 1'b1;
    @(posedge ref_clk);
    lpm_req <= 1'b0;
    // Let the registered load result settle before callers look
    #1;
  endtask
  task automatic store(input logic [15:0] z, input logic [15:0] d);
    z_ptr   <= z;
    r1r0    <= d;
    spm_req <= 1'b1;
    @(posedge ref_clk);
    spm_req <= 1'b0;
  endtask
  task automatic set_ee(input logic val);
    eeprom_write_pending <= val;
  endtask
endmodule

// ===== sim/flash_selfprog_tb.sv
`timescale 1ns/1ns
module flash_selfprog_tb import flash_spm_pkg::*;;
  localparam logic [7:0] FL = 8'h12;
  localparam logic [7:0] FH = 8'h34;
  localparam logic [2:0] FE = 3'h5;
  localparam logic [5:0] LK = 6'h2A;
  localparam logic [7:0] CAL = 8'h77;
  // Arbitrary signature values
  localparam logic [7:0] S1 = 8'h1E;
  localparam logic [7:0] S2 = 8'h2D;
  localparam logic [7:0] S3 = 8'h4B;
  logic        ref_clk, rst_n, por_n, reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, lpm_data, flash_rdata, v;
  logic [15:0] z_ptr, r1r0, buf_data;
  logic        lpm_req, spm_req, eeprom_write_pending, rc_osc;
  logic [13:0] fetch_addr, boot_start;
  logic [1:0]  boot_size_fuses;
  logic        fetch_blocked, region_busy_flag, buf_load, buf_clear;
  logic        flash_busy, flash_erase, flash_write, lock_write;
  logic [5:0]  buf_word;
  logic [7:0]  flash_page;
  logic [7:0]  fuse_low_prog = FL;
  logic [7:0]  fuse_high_prog = FH;
  logic [2:0]  fuse_ext_prog = FE;
  logic [5:0]  lock_prog = LK;
  logic [7:0]  osc_cal = CAL;
  logic [7:0]  fexp [4] = '{~FL, {2'b11, ~LK}, {5'h1F, ~FE}, ~FH};
  logic [7:0]  sexp [4] = '{S1, CAL, S2, S3};
  logic [15:0] sadr [4] = '{16'h0, 16'h1, 16'h2, 16'h4};
  int          n_errors = 0;
  int          n_tests = 0;

  flash_selfprog #(
    .PROG_TICKS(8),
    .SIG_BYTE1 (S1),
    .SIG_BYTE2 (S2),
    .SIG_BYTE3 (S3)
  ) u_dut (.*);
  boot_core_model u_core (.*);

  always #20 ref_clk = ~ref_clk;

  // ------
  // Tasks
  // ------
  task automatic chk(input string what, input logic [23:0] seen,
                     input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic poll;
    logic [7:0] d;
    d = 8'h01;
    for (int i = 0; i < 400 && d[0] !== 1'b0; i++)
      rd(4'h0, d);
    if (d[0] !== 1'b0) begin
      n_errors++;
      finish_test();
    end
  endtask

  // ------
  // Sequence
  // ------
  initial begin
    {ref_clk, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    rst_n = 1'b0;
    por_n = 1'b0;
    boot_size_fuses = 2'b11;
    fetch_addr = 14'h3F00;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    for (int z = 0; z < 4; z++) begin
      wr(4'h0, 8'h09);
      u_core.load(16'(z), (5 - z) % 3);
      chk("fuse", lpm_data, fexp[z]);
    end
    rd(4'h0, v);
    chk("ctrl", v, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 8'h21);
      u_core.load(sadr[i], i % 3);
      chk("sig", lpm_data, sexp[i]);
    end
    wr(4'h0, 8'h21);
    u_core.load(16'h0001, 3);
    chk("late", lpm_data, 8'h5B);
    rd(4'h0, v);
    chk("ctrl", v, 8'h00);
    u_core.set_ee(1'b1);
    wr(4'h0, 8'h09);
    rd(4'h1, v);
    chk("stat", v, 8'h02);
    rd(4'h0, v);
    chk("ee", v, 8'h00);
    rd(4'h7, v);
    chk("unmap", v, 8'h00);
    u_core.set_ee(1'b0);
    for (int b = 0; b < 4; b++) begin
      boot_size_fuses <= 2'(b);
      repeat (2) @(posedge ref_clk);
      #1 chk("boot", boot_start, 14'h3FFF + 14'h1 - (14'h0100 << (3 - b)));
    end
    wr(4'h0, 8'h01);
    u_core.store(16'h0046, 16'hBEEF);
    #1 chk("buf", {buf_load, buf_word, buf_data}, {1'b1, 6'h23, 16'hBEEF});
    fetch_addr <= 14'h0100;
    wr(4'h0, 8'h03);
    u_core.store(16'h0000, 16'h0000);
    rd(4'h0, v);
    chk("erase", v, 8'h43);
    chk("blk", fetch_blocked, 1'b1);
    poll();
    rd(4'h0, v);
    chk("rbusy", v, 8'h40);
    chk("blk", fetch_blocked, 1'b1);
    wr(4'h0, 8'h11);
    u_core.store(16'h0000, 16'h0000);
    #1 chk("clr", buf_clear, 1'b1);
    rd(4'h0, v);
    chk("reen", v, 8'h00);
    chk("open", fetch_blocked, 1'b0);
    wr(4'h0, 8'h09);
    u_core.store(16'h0001, 16'hFFC3);
    #1 chk("lock", {lock_write, region_busy_flag}, 2'b10);
    poll();
    wr(4'h0, 8'h05);
    u_core.store(16'h0080, 16'h0000);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk("rst", flash_busy, 1'b1);
    chk("wrpg", {flash_write, flash_page}, {1'b1, 8'h01});
    for (int i = 0; i < 400 && flash_busy !== 1'b0; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("done", flash_busy, 1'b0);
    finish_test();
  end
endmodule
